//--- src/dactc_top.sv
// Purpose: Data holding, trigger and transfer logic of a single 12-bit converter channel.
// Assumes: AXI4-Lite slave; trigger inputs are one-cycle pulses synchronous to ref_clk_in.
// Notes:   The rules that the logic keeps are listed below.
// Behaviour
// - Three holding formats, one shared register.
// - Enable bit drives analog power only.
// - Buffer-off bit inverted sense: 1 disables.
// - Output code register ignores bus writes.
// - Untriggered write transfers one cycle later.
// - Trigger enable gates transfer on trigger.
// - Three-bit source field selects trigger.
// - Code 010 selects timer seven trigger.
// - Source field ignored while triggering off.
// - Hardware trigger transfer after three cycles.
// - Software trigger transfer after one cycle.
// - Software trigger bit self-clears after transfer.
// - Control bit 12 enables DMA service.
// - Control bit 13 enables underrun interrupt.
// - Output code passed unchanged to converter.
// - Control register resets to zero.
// - Underrun flag bit 13, write one clears.
// - Dual 8-bit register feeds same path.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module dactc_top #(
    parameter int CODE_W = 12
) (
    // Clock and reset.
    input  wire logic                 ref_clk_in,
    input  wire logic                 srst_in,
    // AXI4-Lite write channels.
    input  wire logic [7:0]           s_awaddr_in,
    input  wire logic                 s_awvalid_in,
    output logic                      s_awready_out,
    input  wire logic [31:0]          s_wdata_in,
    input  wire logic [3:0]           s_wstrb_in,
    input  wire logic                 s_wvalid_in,
    output logic                      s_wready_out,
    output logic [1:0]                s_bresp_out,
    output logic                      s_bvalid_out,
    input  wire logic                 s_bready_in,
    // AXI4-Lite read channels.
    input  wire logic [7:0]           s_araddr_in,
    input  wire logic                 s_arvalid_in,
    output logic                      s_arready_out,
    output logic [31:0]               s_rdata_out,
    output logic [1:0]                s_rresp_out,
    output logic                      s_rvalid_out,
    input  wire logic                 s_rready_in,
    // Trigger sources and DMA handshake.
    input  wire dactc_pkg::dactc_trig_t trig_in,
    output logic                      dma_req_out,
    input  wire logic                 dma_ack_in,
    // Analog side.
    output logic [CODE_W-1:0]         output_code_out,
    output logic                      analog_power_enable_out,
    output logic                      output_buffer_off_out,
    output logic                      underrun_irq_out
);
    dactc_pkg::dactc_ctrl_t ctrl_ff;
    logic [CODE_W-1:0] hold_ff;
    logic [CODE_W-1:0] code_ff;
    logic              soft_trigger_bit_ff;
    logic              underrun_flag_ff;
    logic              dma_req_ff;
    logic              direct_ff;
    logic [7:0]        awaddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              aw_have_ff;
    logic              w_have_ff;
    logic              do_write;
    logic              hold_write;
    logic              hw_sel_pulse;
    logic              hw_done;
    logic              sw_done;
    logic              trig_evt;
    logic              transfer;
    logic [31:0]       rd_word;
    logic              rd_ok;
    logic [CODE_W:0]   hold_dec;

    // Decode a holding register write into a 12-bit code, or flag it as no holding register.
    function automatic logic [CODE_W:0] hold_decode(input logic [7:0] addr, input logic [31:0] d);
        unique case (addr)
            dactc_pkg::OFF_HR12, dactc_pkg::OFF_HR12B: hold_decode = {1'b1, d[CODE_W-1:0]};
            dactc_pkg::OFF_HL12:   hold_decode = {1'b1, d[CODE_W+3:4]};
            dactc_pkg::OFF_HR8, dactc_pkg::OFF_HDUAL8: hold_decode = {1'b1, d[7:0], 4'h0};
            default:               hold_decode = '0;
        endcase
    endfunction

    // Place the control fields at their register bit positions; the struct order is not the bit order.
    function automatic logic [31:0] ctrl_to_word(input dactc_pkg::dactc_ctrl_t c);
        logic [31:0] w;
        w                                = '0;
        w[dactc_pkg::CTRL_EN_BIT]        = c.en;
        w[dactc_pkg::CTRL_BOFF_BIT]      = c.boff;
        w[dactc_pkg::CTRL_TEN_BIT]       = c.ten;
        w[dactc_pkg::CTRL_TSEL_LO +: 3]  = c.tsel;
        w[dactc_pkg::CTRL_DMA_BIT]       = c.dma;
        w[dactc_pkg::CTRL_UIE_BIT]       = c.uie;
        return w;
    endfunction

    // Pick the control fields out of a register word.
    function automatic dactc_pkg::dactc_ctrl_t ctrl_from_word(input logic [31:0] w);
        dactc_pkg::dactc_ctrl_t c;
        c.en   = w[dactc_pkg::CTRL_EN_BIT];
        c.boff = w[dactc_pkg::CTRL_BOFF_BIT];
        c.ten  = w[dactc_pkg::CTRL_TEN_BIT];
        c.tsel = w[dactc_pkg::CTRL_TSEL_LO +: 3];
        c.dma  = w[dactc_pkg::CTRL_DMA_BIT];
        c.uie  = w[dactc_pkg::CTRL_UIE_BIT];
        return c;
    endfunction

    // Write address and data are taken independently, in either order.
    assign do_write = aw_have_ff && w_have_ff && !s_bvalid_out;
    assign hold_dec   = hold_decode(awaddr_ff, wdata_ff);
    assign hold_write = do_write && hold_dec[CODE_W];

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            awaddr_ff     <= '0;
            wdata_ff      <= '0;
            wstrb_ff      <= '0;
            s_awready_out <= 1'b0;
            s_wready_out  <= 1'b0;
            s_bvalid_out  <= 1'b0;
            s_bresp_out   <= dactc_pkg::OKAY;
        end else begin
            s_awready_out <= !aw_have_ff && !s_awready_out && !s_bvalid_out;
            s_wready_out  <= !w_have_ff && !s_wready_out && !s_bvalid_out;
            if (s_awvalid_in && s_awready_out) begin
                aw_have_ff <= 1'b1;
                awaddr_ff  <= s_awaddr_in;
                s_awready_out <= 1'b0;
            end
            if (s_wvalid_in && s_wready_out) begin
                w_have_ff <= 1'b1;
                wdata_ff  <= s_wdata_in;
                wstrb_ff  <= s_wstrb_in;
                s_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
                s_bvalid_out <= 1'b1;
                s_bresp_out  <= (hold_dec[CODE_W] || awaddr_ff == dactc_pkg::OFF_CTRL ||
                                 awaddr_ff == dactc_pkg::OFF_SOFT_TRIGGER_SOURCE || awaddr_ff == dactc_pkg::OFF_FLAGS ||
                                 awaddr_ff == dactc_pkg::OFF_OUTCODE) ? dactc_pkg::OKAY : dactc_pkg::SLVERR;
            end else if (s_bvalid_out && s_bready_in) begin
                s_bvalid_out <= 1'b0;
            end
        end
    end

    // Control register; partial byte writes honour the strobes, reserved bits stay zero.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctrl_ff <= ctrl_from_word(dactc_pkg::CTRL_RESET);
        end else if (do_write && awaddr_ff == dactc_pkg::OFF_CTRL) begin
            if (wstrb_ff[0]) begin
                ctrl_ff.en   <= wdata_ff[dactc_pkg::CTRL_EN_BIT];
                ctrl_ff.boff <= wdata_ff[dactc_pkg::CTRL_BOFF_BIT];
                ctrl_ff.ten  <= wdata_ff[dactc_pkg::CTRL_TEN_BIT];
                ctrl_ff.tsel <= wdata_ff[dactc_pkg::CTRL_TSEL_LO +: 3];
            end
            if (wstrb_ff[1]) begin
                ctrl_ff.dma <= wdata_ff[dactc_pkg::CTRL_DMA_BIT];
                ctrl_ff.uie <= wdata_ff[dactc_pkg::CTRL_UIE_BIT];
            end
        end
    end

    // Holding register takes every format; the output code never sees a bus write.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            hold_ff <= '0;
        end else if (hold_write && wstrb_ff[0]) begin
            hold_ff <= hold_dec[CODE_W-1:0];
        end
    end

    // Hardware trigger selection; the field only matters while triggering is enabled.
    always_comb begin
        hw_sel_pulse = 1'b0;
        if (ctrl_ff.ten) begin
            unique case (ctrl_ff.tsel)
                dactc_pkg::TSEL_TMR6:  hw_sel_pulse = trig_in.tmr6;
                dactc_pkg::TSEL_TMR3:  hw_sel_pulse = trig_in.tmr3;
                dactc_pkg::TSEL_TIMER_SEVEN:  hw_sel_pulse = trig_in.timer_seven;
                dactc_pkg::TSEL_TMR15: hw_sel_pulse = trig_in.tmr15;
                dactc_pkg::TSEL_TMR2:  hw_sel_pulse = trig_in.tmr2;
                dactc_pkg::TSEL_EXT:   hw_sel_pulse = trig_in.ext9;
                default:               hw_sel_pulse = 1'b0;                       // Reserved and software codes.
            endcase
        end
    end

    // Hardware triggers take three cycles, the software one takes one.
    // A pulse sampled at edge T loads the code at T+3, counted like the software bit that loads one edge later.
    dactc_delay #(.DEPTH(dactc_pkg::HW_TRIG_CYCLES)) u_hw_delay (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .pulse_in   (hw_sel_pulse),
        .pulse_out  (hw_done)
    );

    assign sw_done = soft_trigger_bit_ff && ctrl_ff.ten && ctrl_ff.tsel == dactc_pkg::TSEL_SOFT;
    assign trig_evt = hw_done || sw_done;
    assign transfer = ctrl_ff.ten ? trig_evt : direct_ff;

    // A holding write with triggering off transfers on the next cycle.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            direct_ff <= 1'b0;
        end else begin
            direct_ff <= hold_write && !ctrl_ff.ten;
        end
    end

    // Output code only loads from the holding register.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            code_ff <= '0;
        end else if (transfer) begin
            code_ff <= hold_ff;
        end
    end

    // Software trigger bit: set by write of one, cleared by software or by the transfer.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            soft_trigger_bit_ff <= 1'b0;
        end else if (do_write && awaddr_ff == dactc_pkg::OFF_SOFT_TRIGGER_SOURCE && wstrb_ff[0]) begin
            soft_trigger_bit_ff <= wdata_ff[dactc_pkg::SOFT_TRIGGER_SOURCE_BIT];
        end else if (sw_done) begin
            soft_trigger_bit_ff <= 1'b0;
        end
    end

    // DMA request on each trigger; a trigger while still pending flags underrun.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            dma_req_ff <= 1'b0;
        end else if (ctrl_ff.dma && trig_evt) begin
            dma_req_ff <= 1'b1;
        end else if (dma_ack_in || !ctrl_ff.dma) begin
            dma_req_ff <= 1'b0;
        end
    end

    // Underrun flag: hardware set wins over a same-cycle write-one clear.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            underrun_flag_ff <= 1'b0;
        end else if (ctrl_ff.dma && trig_evt && dma_req_ff && !dma_ack_in) begin
            underrun_flag_ff <= 1'b1;
        end else if (do_write && awaddr_ff == dactc_pkg::OFF_FLAGS && wstrb_ff[1] &&
                     wdata_ff[dactc_pkg::FLAG_UDR_BIT]) begin
            underrun_flag_ff <= 1'b0;
        end
    end

    // Registered outputs to the analog part and interrupt line.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            output_code_out         <= '0;
            analog_power_enable_out <= 1'b0;
            output_buffer_off_out   <= 1'b0;
            underrun_irq_out        <= 1'b0;
            dma_req_out             <= 1'b0;
        end else begin
            output_code_out         <= (transfer) ? hold_ff : code_ff;
            analog_power_enable_out <= ctrl_ff.en;
            output_buffer_off_out   <= ctrl_ff.boff;
            underrun_irq_out        <= ctrl_ff.uie && underrun_flag_ff;
            dma_req_out             <= dma_req_ff;
        end
    end

    // Read mux; the software trigger register reads as zero being write-only.
    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        unique case (s_araddr_in)
            dactc_pkg::OFF_CTRL:    rd_word = ctrl_to_word(ctrl_ff) & dactc_pkg::CTRL_MASK;
            dactc_pkg::OFF_SOFT_TRIGGER_SOURCE:   rd_word = '0;
            dactc_pkg::OFF_HR12, dactc_pkg::OFF_HR12B: rd_word = 32'(hold_ff);
            dactc_pkg::OFF_HL12:    rd_word = {16'h0000, hold_ff, 4'h0};
            dactc_pkg::OFF_HR8, dactc_pkg::OFF_HDUAL8: rd_word = {24'h00_0000, hold_ff[CODE_W-1:4]};
            dactc_pkg::OFF_OUTCODE: rd_word = 32'(code_ff);
            dactc_pkg::OFF_FLAGS:   rd_word = 32'(underrun_flag_ff) << dactc_pkg::FLAG_UDR_BIT;
            default:                rd_ok   = 1'b0;
        endcase
    end

    // Read channel: one read in flight; answer two cycles after the address is offered.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_arready_out <= 1'b0;
            s_rvalid_out  <= 1'b0;
            s_rdata_out   <= '0;
            s_rresp_out   <= dactc_pkg::OKAY;
        end else if (s_arvalid_in && s_arready_out) begin
            s_arready_out <= 1'b0;
            s_rvalid_out  <= 1'b1;
            s_rdata_out   <= rd_word;
            s_rresp_out   <= rd_ok ? dactc_pkg::OKAY : dactc_pkg::SLVERR;
        end else if (s_rvalid_out) begin
            if (s_rready_in) begin
                s_rvalid_out <= 1'b0;
            end
        end else begin
            s_arready_out <= s_arvalid_in && !s_arready_out;
        end
    end

    // Assertions.
    untrig_xfer_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        hold_write && !ctrl_ff.ten |=> ##1 output_code_out == $past(hold_ff))
        else $error("Untriggered write did not reach output code.");
    hw_trig_delay_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        hw_sel_pulse |-> ##3 transfer)
        else $error("Hardware trigger transfer not at third cycle.");
    sw_clear_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        sw_done && !(do_write && awaddr_ff == dactc_pkg::OFF_SOFT_TRIGGER_SOURCE) |=> !soft_trigger_bit_ff)
        else $error("Software trigger bit not cleared after transfer.");
    code_stable_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !transfer |=> code_ff == $past(code_ff))
        else $error("Output code changed without a transfer.");
    src_ignored_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        !ctrl_ff.ten |-> !hw_sel_pulse && !sw_done)
        else $error("Trigger taken while triggering disabled.");
    underrun_set_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        ctrl_ff.dma && trig_evt && dma_req_ff && !dma_ack_in |=> underrun_flag_ff)
        else $error("Missed DMA service did not flag underrun.");
    irq_gate_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        underrun_irq_out |-> $past(ctrl_ff.uie) && $past(underrun_flag_ff))
        else $error("Underrun interrupt without enable and flag.");
    buf_sense_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        ##1 output_buffer_off_out == $past(ctrl_ff.boff))
        else $error("Buffer-off output does not follow control bit.");
    cov_untrig_c: cover property (@(posedge ref_clk_in) hold_write && !ctrl_ff.ten);
    cov_hw_c: cover property (@(posedge ref_clk_in) hw_done);
    cov_sw_c: cover property (@(posedge ref_clk_in) sw_done);
    cov_udr_c: cover property (@(posedge ref_clk_in) underrun_flag_ff);
endmodule

//--- src/dactc_pkg.sv
// Purpose: Shared constants and types for the converter data and trigger control block.
// Assumes: One 250 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Register offsets are byte addresses; every field position is named here.
package dactc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_SOFT_TRIGGER_SOURCE   = 8'h04;
    localparam logic [7:0] OFF_HR12    = 8'h08;
    localparam logic [7:0] OFF_HL12    = 8'h0c;
    localparam logic [7:0] OFF_HR8     = 8'h10;
    localparam logic [7:0] OFF_HR12B   = 8'h14;
    localparam logic [7:0] OFF_HDUAL8  = 8'h28;
    localparam logic [7:0] OFF_OUTCODE = 8'h2c;
    localparam logic [7:0] OFF_FLAGS   = 8'h34;
    // Control register field positions.
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_BOFF_BIT = 1;
    localparam int CTRL_TEN_BIT  = 2;
    localparam int CTRL_TSEL_LO  = 3;
    localparam int CTRL_DMA_BIT  = 12;
    localparam int CTRL_UIE_BIT  = 13;
    localparam int FLAG_UDR_BIT  = 13;
    localparam int SOFT_TRIGGER_SOURCE_BIT     = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_303f;
    // Trigger source codes.
    localparam logic [2:0] TSEL_TMR6  = 3'h0;
    localparam logic [2:0] TSEL_TMR3  = 3'h1;
    localparam logic [2:0] TSEL_TIMER_SEVEN  = 3'h2;
    localparam logic [2:0] TSEL_TMR15 = 3'h3;
    localparam logic [2:0] TSEL_TMR2  = 3'h4;
    localparam logic [2:0] TSEL_EXT   = 3'h6;
    localparam logic [2:0] TSEL_SOFT  = 3'h7;
    // Transfer delays in clock cycles after the trigger.
    localparam int HW_TRIG_CYCLES = 3;
    localparam int SW_TRIG_CYCLES = 1;
    localparam logic [1:0] SLVERR = 2'h2;
    localparam logic [1:0] OKAY   = 2'h0;
    // Hardware trigger inputs as one bundle.
    typedef struct packed {
        logic tmr6;
        logic tmr3;
        logic timer_seven;
        logic tmr15;
        logic tmr2;
        logic ext9;
    } dactc_trig_t;
    // Control fields.
    typedef struct packed {
        logic       uie;
        logic       dma;
        logic [2:0] tsel;
        logic       ten;
        logic       boff;
        logic       en;
    } dactc_ctrl_t;
endpackage

//--- src/dactc_delay.sv
// Purpose: Fixed-length pulse delay line for trigger timing.
// Assumes: Synchronous active-high reset.
// Notes:   A depth of one gives a single register stage.
`timescale 1ns/1ps
module dactc_delay #(
    parameter int DEPTH = 3
) (
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic srst_in,
    // Pulse in and out.
    input  wire logic pulse_in,
    output logic      pulse_out
);
    logic [DEPTH-1:0] pipe_ff;

    generate
        if (DEPTH == 1) begin : g_single
            // A single stage only registers the pulse; no shift slice exists to elaborate.
            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    pipe_ff <= '0;
                end else begin
                    pipe_ff[0] <= pulse_in;
                end
            end
        end else begin : g_chain
            // Shift the pulse through DEPTH stages.
            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    pipe_ff <= '0;
                end else begin
                    pipe_ff <= {pipe_ff[DEPTH-2:0], pulse_in};
                end
            end
        end
    endgenerate

    assign pulse_out = pipe_ff[DEPTH-1];
endmodule

//--- verif/dactc_far_model.sv
// Purpose: Far-side model: timer and external trigger pulses plus a DMA acknowledger.
// Assumes: Trigger pulses last one cycle; acknowledge is a one-cycle pulse.
// Notes:   Clearing ack_en_in starves the request so that underrun can be provoked.
`timescale 1ns/1ps
module dactc_far_model (
    // Clock and reset.
    input  wire logic              ref_clk_in,
    input  wire logic              srst_in,
    // Bench commands.
    input  wire logic              fire_in,
    input  wire logic [2:0]        code_in,
    input  wire logic              ack_en_in,
    // Design side.
    output dactc_pkg::dactc_trig_t trig_out,
    input  wire logic              dma_req_in,
    output logic                   dma_ack_out
);
    logic [1:0] wait_ff;

    // One-hot pulse that lasts exactly as long as fire_in, one cycle from the bench.
    always_comb begin
        trig_out = '0;
        if (fire_in) begin
            case (code_in)
                3'h0: trig_out.tmr6 = 1'b1;
                3'h1: trig_out.tmr3 = 1'b1;
                3'h2: trig_out.timer_seven = 1'b1;
                3'h3: trig_out.tmr15 = 1'b1;
                3'h4: trig_out.tmr2 = 1'b1;
                3'h6: trig_out.ext9 = 1'b1;
                default: trig_out = '0;
            endcase
        end
    end

    // Serve a pending request after four cycles; a slow master is the hazard tested.
    always_ff @(posedge ref_clk_in) begin
        dma_ack_out <= 1'b0;
        if (srst_in || !dma_req_in) begin
            wait_ff <= 2'h0;
        end else if (ack_en_in && !dma_ack_out) begin
            wait_ff <= wait_ff + 2'h1;
            if (wait_ff == 2'h3) begin
                dma_ack_out <= 1'b1;
            end
        end
    end
endmodule

//--- verif/dac_channel_data_trigger_ctrl_tb.sv
// Purpose: Self-checking bench for the converter data and trigger block.
// Assumes: AXI4-Lite master with bready and rready held high throughout.
// Notes:   Random data with full-scale and zero corners; seed fixed.
`timescale 1ns/1ps
module dac_channel_data_trigger_ctrl_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic [7:0]             awaddr = 8'h00;
    logic [7:0]             araddr = 8'h00;
    logic                   awvalid = 1'b0;
    logic                   wvalid = 1'b0;
    logic                   arvalid = 1'b0;
    logic [31:0]            wdata = 32'h0000_0000;
    logic                   fire = 1'b0;
    logic                   ack_en = 1'b1;
    logic [2:0]             fcode = 3'h0;
    logic                   awready, wready, bvalid, arready, rvalid, req, ack, pwr, boff, irq;
    logic [1:0]             bresp, rresp, resp;
    logic [31:0]            rdata, rd_v, d;
    logic [11:0]            code, e;
    dactc_pkg::dactc_trig_t trig;
    logic [7:0]             hold_a [5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h28};
    logic [2:0]             srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    int                     num_errors = 0;
    int                     comparisons = 0;

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    dactc_top #(.CODE_W(12)) dactc_top_inst (.ref_clk_in(clk), .srst_in(rst),
        .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
        .s_wstrb_in(4'hf), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
        .s_bvalid_out(bvalid), .s_bready_in(1'b1), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
        .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
        .s_rready_in(1'b1), .trig_in(trig), .dma_req_out(req), .dma_ack_in(ack),
        .output_code_out(code), .analog_power_enable_out(pwr), .output_buffer_off_out(boff),
        .underrun_irq_out(irq));
    dactc_far_model dactc_far_model_inst (.ref_clk_in(clk), .srst_in(rst), .fire_in(fire),
        .code_in(fcode), .ack_en_in(ack_en), .trig_out(trig), .dma_req_in(req), .dma_ack_out(ack));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Only bvalid or the watchdog ends this wait.
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd_v = rdata;
        resp = rresp;
    endtask

    // Trigger is sampled high at the second edge of this task.
    task automatic pulse(input logic [2:0] c);
        @(posedge clk);
        fire <= 1'b1;
        fcode <= c;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    function automatic logic [11:0] expc(input logic [7:0] a, input logic [31:0] v);
        if (a == dactc_pkg::OFF_HL12) return v[15:4];
        if (a == dactc_pkg::OFF_HR8 || a == dactc_pkg::OFF_HDUAL8) return {v[7:0], 4'h0};
        return v[11:0];
    endfunction

    task automatic conclude();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h7baa_1321));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(dactc_pkg::OFF_CTRL);
        chk(rd_v, dactc_pkg::CTRL_RESET);
        chk({pwr, boff, irq, req, code}, 32'h0);
        // Random control with the trigger off, then a direct transfer per format.
        for (int i = 0; i < 10; i++) begin
            d = $urandom & 32'hffff_fffb;
            wr(dactc_pkg::OFF_CTRL, d);
            rd(dactc_pkg::OFF_CTRL);
            chk(rd_v, d & dactc_pkg::CTRL_MASK);
            chk({pwr, boff}, {d[0], d[1]});
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            wr(hold_a[i % 5], d);
            e = expc(hold_a[i % 5], d);
            @(posedge clk);
            #1;
            chk(code, e);
            rd(dactc_pkg::OFF_OUTCODE);
            chk(rd_v, {20'h0, e});
        end
        wr(dactc_pkg::OFF_OUTCODE, ~{20'h0, e});
        rd(dactc_pkg::OFF_OUTCODE);
        chk(rd_v, {20'h0, e});
        wr(8'h20, 32'h1);
        chk(resp, dactc_pkg::SLVERR);
        rd(8'h20);
        chk(resp, dactc_pkg::SLVERR);
        // Every hardware source: held back, ignored when not selected, three cycles when fired.
        foreach (srcs[i]) begin
            wr(dactc_pkg::OFF_CTRL, 32'h4 | (32'(srcs[i]) << 3));
            d = $urandom;
            wr(dactc_pkg::OFF_HR12, d);
            pulse((srcs[i] == 3'h0) ? 3'h1 : 3'h0);
            repeat (4) @(posedge clk);
            #1;
            chk(code, e);
            pulse(srcs[i]);
            repeat (2) @(posedge clk);
            #1;
            chk(code, e);
            @(posedge clk);
            #1;
            e = d[11:0];
            chk(code, e);
        end
        // Software trigger.
        wr(dactc_pkg::OFF_CTRL, 32'h0000_003c);
        d = $urandom;
        wr(dactc_pkg::OFF_HL12, d);
        repeat (3) @(posedge clk);
        #1;
        chk(code, e);
        wr(dactc_pkg::OFF_SOFT_TRIGGER_SOURCE, 32'h1);
        @(posedge clk);
        #1;
        chk(code, d[15:4]);
        rd(dactc_pkg::OFF_SOFT_TRIGGER_SOURCE);
        chk(rd_v, 32'h0);
        // A cleared bit must not carry the next holding write through.
        wr(dactc_pkg::OFF_HL12, ~d);
        repeat (3) @(posedge clk);
        #1;
        chk(code, d[15:4]);
        // DMA served, then starved into underrun, masked and cleared.
        wr(dactc_pkg::OFF_CTRL, 32'h0000_3004);
        pulse(3'h0);
        for (int n = 0; n < 8 && !req; n++) @(posedge clk);
        chk(req, 1'b1);
        for (int n = 0; n < 12 && req; n++) @(posedge clk);
        chk(req, 1'b0);
        ack_en <= 1'b0;
        pulse(3'h0);
        repeat (4) @(posedge clk);
        pulse(3'h0);
        repeat (4) @(posedge clk);
        #1;
        chk(irq, 1'b1);
        rd(dactc_pkg::OFF_FLAGS);
        chk(rd_v[13], 1'b1);
        ack_en <= 1'b1;
        wr(dactc_pkg::OFF_CTRL, 32'h0000_1004);
        repeat (3) @(posedge clk);
        #1;
        chk(irq, 1'b0);
        wr(dactc_pkg::OFF_FLAGS, 32'h0000_2000);
        rd(dactc_pkg::OFF_FLAGS);
        chk(rd_v[13], 1'b0);
        conclude();
    end
endmodule
